/* core/sdw_walker.sv */
// Descriptor chain walker for a split-format request queue.
// Assumes a memory port returning one descriptor per accepted request, in order.
`timescale 1ns/1ps

// Operation
// R01: Driver aligns each queue part.
// R02: Alignments sixteen, two and four bytes.
// R03: Queue size power of two, at most 32768.
// R04: Legacy queue spans two aligned pages.
// R05: Legacy order: table, avail, pad, used.
// R06: Legacy uses guest order, else little-endian.
// R07: Accept any split; cap chain length.
// R08: Writable descriptors follow readable ones.
// R09: Descriptor is address, length, flags, next.
// R10: Flag one continues chain at next.
// R11: Flag two writable, flag four indirect.
// R12: Never write readable buffers.
// R13: Table holds queue size entries.
// R14: Chain total at most 2^32 bytes.
// R15: In-order uses table order from zero.
// R16: In-order next is x+1, wraps to zero.
// R17: Indirect table holds len/16 entries.
// R18: Indirect walk starts entry zero.
// R19: In-order indirect entries are sequential.
// R20: Indirect only once, never nested.
// R21: Chain no longer than queue size.
// R22: Never indirect and continue together.
// R23: Ignore writable flag on indirect descriptor.
// R24: Accept chain ending in indirect descriptor.
// R25: Legacy any-layout drops framing assumptions.
// R26: Flag error on bad index or length.
module sdw_walker (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               ce,
    input  wire logic [63:0]        table_base,
    input  wire logic [15:0]        queue_size,
    input  wire logic               legacy_mode,
    input  wire logic               native_be,
    input  wire logic               start,
    input  wire logic [15:0]        head_idx,
    output logic                    busy,
    output logic                    done,
    output logic                    error,
    output logic [1:0]              error_code,
    output logic                    mem_req_valid,
    input  wire logic               mem_req_ready,
    output logic [63:0]             mem_req_addr,
    input  wire logic               mem_rsp_valid,
    input  wire logic [127:0]       mem_rsp_data,
    output logic                    seg_valid,
    input  wire logic               seg_ready,
    output sdw_pkg::sdw_seg_t       seg_data
);
    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    sdw_pkg::sdw_state_t st_q, st_d;        // Walker state.
    logic [63:0]  tbase_q, tbase_d;         // Base of the table being walked.
    logic [15:0]  tsize_q, tsize_d;         // Entry count of that table.
    logic [15:0]  idx_q, idx_d;             // Descriptor being fetched.
    logic [16:0]  cnt_q, cnt_d;             // Descriptors walked so far in that table.
    logic         ind_q, ind_d;             // Walking an indirect table.
    logic         seen_wr_q, seen_wr_d;     // A writable segment was seen.
    logic         busy_q, busy_d;
    logic         done_q, done_d;
    logic         err_q, err_d;
    logic [1:0]   code_q, code_d;
    logic         mreq_q, mreq_d;
    logic [63:0]  maddr_q, maddr_d;
    sdw_pkg::sdw_desc_t desc_q, desc_d;     // Descriptor held for emit.
    sdw_pkg::sdw_desc_t dec;                // Decoded memory answer.
    sdw_pkg::sdw_seg_t  seg_w;
    logic         fifo_ready, fifo_push;
    logic         be_sel;

    // Guest byte order applies only in legacy mode. [R06]
    assign be_sel = legacy_mode && native_be;

    // Field decode of the incoming descriptor. [R09]
    sdw_decode u_dec (
        .raw       (mem_rsp_data),
        .native_be (be_sel),
        .desc      (dec)
    );

    // Byte address of entry idx in a table of 16-byte descriptors. [R13] [R05] [R04]
    function automatic logic [63:0] ent_addr(input logic [63:0] base, input logic [15:0] i);
        return base + {44'h0, i, 4'h0};
    endfunction

    // ------------------------------------------------------------
    // Walk control.
    // ------------------------------------------------------------
    // One descriptor at a time: fetch, wait for the answer, then emit or follow.
    always_comb begin
        st_d      = st_q;
        tbase_d   = tbase_q;
        tsize_d   = tsize_q;
        idx_d     = idx_q;
        cnt_d     = cnt_q;
        ind_d     = ind_q;
        seen_wr_d = seen_wr_q;
        busy_d    = busy_q;
        done_d    = 1'b0;
        err_d     = err_q;
        code_d    = code_q;
        mreq_d    = mreq_q;
        maddr_d   = maddr_q;
        desc_d    = desc_q;
        fifo_push = 1'b0;
        seg_w     = '0;
        case (st_q)
            sdw_pkg::SDW_IDLE: begin
                if (start) begin
                    // Head index is range checked like any next index. [R26]
                    tbase_d   = table_base;
                    tsize_d   = queue_size;     // [R03]
                    idx_d     = head_idx;
                    cnt_d     = '0;
                    ind_d     = 1'b0;
                    seen_wr_d = 1'b0;
                    busy_d    = 1'b1;
                    err_d     = 1'b0;
                    code_d    = sdw_pkg::ERR_NONE;
                    st_d      = sdw_pkg::SDW_FETCH;
                end
            end
            sdw_pkg::SDW_FETCH: begin
                if (idx_q >= tsize_q) begin
                    code_d = sdw_pkg::ERR_RANGE;                      // [R26]
                    st_d   = sdw_pkg::SDW_ERR;
                end else if (cnt_q >= {1'b0, tsize_q}) begin
                    // Longest legal chain is one table's worth. [R13] [R21] [R07] [R25]
                    code_d = sdw_pkg::ERR_LONG;                       // [R26]
                    st_d   = sdw_pkg::SDW_ERR;
                end else begin
                    mreq_d  = 1'b1;
                    maddr_d = ent_addr(tbase_q, idx_q);
                    st_d    = sdw_pkg::SDW_WAIT;
                end
            end
            sdw_pkg::SDW_WAIT: begin
                if (mreq_q && mem_req_ready) begin
                    mreq_d = 1'b0;
                end
                if (mem_rsp_valid) begin
                    desc_d = dec;
                    cnt_d  = cnt_q + 17'h00001;
                    if (!ind_q && (dec.flags & sdw_pkg::FLAG_INDIRECT) != '0) begin
                        // Enter the indirect table at entry zero, ignoring the
                        // writable flag here; it ends the outer chain. [R17] [R18] [R23] [R24]
                        tbase_d = dec.addr;
                        tsize_d = 16'(dec.len >> sdw_pkg::DESC_SHIFT);
                        idx_d   = '0;
                        cnt_d   = '0;
                        ind_d   = 1'b1;
                        st_d    = sdw_pkg::SDW_FETCH;
                    end else begin
                        st_d = sdw_pkg::SDW_EMIT;
                    end
                end
            end
            sdw_pkg::SDW_EMIT: begin
                // Writable flag selects the direction the data engine may use. [R11] [R12]
                seg_w.addr   = desc_q.addr;
                seg_w.len    = desc_q.len;
                seg_w.dev_wr = (desc_q.flags & sdw_pkg::FLAG_DEV_WR) != '0;
                seg_w.last   = (desc_q.flags & sdw_pkg::FLAG_CHAIN) == '0;   // [R10]
                if (seen_wr_q && !seg_w.dev_wr) begin
                    code_d = sdw_pkg::ERR_ORDER;
                    st_d   = sdw_pkg::SDW_ERR;
                end else if (fifo_ready) begin
                    fifo_push = 1'b1;
                    seen_wr_d = seen_wr_q | seg_w.dev_wr;
                    if (seg_w.last) begin
                        busy_d = 1'b0;
                        done_d = 1'b1;
                        st_d   = sdw_pkg::SDW_IDLE;
                    end else begin
                        idx_d = desc_q.next;                          // [R10]
                        st_d  = sdw_pkg::SDW_FETCH;
                    end
                end
            end
            sdw_pkg::SDW_ERR: begin
                // Stop the walk and hold the code until the next start. [R26]
                err_d  = 1'b1;
                busy_d = 1'b0;
                done_d = 1'b1;
                st_d   = sdw_pkg::SDW_IDLE;
            end
            default: begin
                st_d = sdw_pkg::SDW_IDLE;
            end
        endcase
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q      <= sdw_pkg::SDW_IDLE;
            tbase_q   <= '0;
            tsize_q   <= '0;
            idx_q     <= '0;
            cnt_q     <= '0;
            ind_q     <= 1'b0;
            seen_wr_q <= 1'b0;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            err_q     <= 1'b0;
            code_q    <= sdw_pkg::ERR_NONE;
            mreq_q    <= 1'b0;
            maddr_q   <= '0;
            desc_q    <= '0;
        end else if (ce) begin
            st_q      <= st_d;
            tbase_q   <= tbase_d;
            tsize_q   <= tsize_d;
            idx_q     <= idx_d;
            cnt_q     <= cnt_d;
            ind_q     <= ind_d;
            seen_wr_q <= seen_wr_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
            err_q     <= err_d;
            code_q    <= code_d;
            mreq_q    <= mreq_d;
            maddr_q   <= maddr_d;
            desc_q    <= desc_d;
        end
    end

    assign busy          = busy_q;
    assign done          = done_q;
    assign error         = err_q;
    assign error_code    = code_q;
    assign mem_req_valid = mreq_q;
    assign mem_req_addr  = maddr_q;

    // ------------------------------------------------------------
    // Segment buffer; a stalled data engine stalls the walk.
    // ------------------------------------------------------------
    sdw_fifo #(
        .WIDTH ($bits(sdw_pkg::sdw_seg_t)),
        .DEPTH (sdw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .in_data   (seg_w),
        .out_valid (seg_valid),
        .out_ready (seg_ready),
        .out_data  (seg_data)
    );

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    sequence s_bad_idx;
        st_q == sdw_pkg::SDW_FETCH && idx_q >= tsize_q;
    endsequence
    property p_range_err;
        @(posedge clk) disable iff (srst)
        (s_bad_idx and ce) ##1 ce |=> err_q && code_q == sdw_pkg::ERR_RANGE;
    endproperty
    a_range_err: assert property (p_range_err) else $error("bad index not flagged"); // [R26]

    property p_no_fetch_bad;
        @(posedge clk) disable iff (srst)
        ce && st_q == sdw_pkg::SDW_FETCH && idx_q >= tsize_q |=> !mreq_q;
    endproperty
    a_no_fetch_bad: assert property (p_no_fetch_bad) else $error("fetched bad index"); // [R26]

    property p_addr;
        @(posedge clk) disable iff (srst)
        ce && st_q == sdw_pkg::SDW_FETCH && idx_q < tsize_q && cnt_q < {1'b0, tsize_q}
        |=> maddr_q == $past(tbase_q) + {44'h0, $past(idx_q), 4'h0};
    endproperty
    a_addr: assert property (p_addr) else $error("descriptor address wrong"); // [R09]

    property p_ind_start;
        @(posedge clk) disable iff (srst)
        ce && st_q == sdw_pkg::SDW_WAIT && mem_rsp_valid && !ind_q
        && (dec.flags & sdw_pkg::FLAG_INDIRECT) != '0 |=> ind_q && idx_q == '0;
    endproperty
    a_ind_start: assert property (p_ind_start) else $error("indirect not at zero"); // [R18]

    property p_no_push_readable_after_wr;
        @(posedge clk) disable iff (srst)
        fifo_push && seen_wr_q |-> seg_w.dev_wr;
    endproperty
    a_no_push_readable_after_wr: assert property (p_no_push_readable_after_wr)
        else $error("readable after writable"); // [R12]

    property p_follow_next;
        @(posedge clk) disable iff (srst)
        ce && fifo_push && !seg_w.last |=> idx_q == $past(desc_q.next);
    endproperty
    a_follow_next: assert property (p_follow_next) else $error("next not followed"); // [R10]

    property p_len_cap;
        @(posedge clk) disable iff (srst)
        cnt_q <= {1'b0, tsize_q} + 17'h00001;
    endproperty
    a_len_cap: assert property (p_len_cap) else $error("chain count runaway"); // [R21]

    property p_done_idle;
        @(posedge clk) disable iff (srst)
        ce && fifo_push && seg_w.last |=> done_q && !busy_q ##1 !done_q || !ce;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done not one pulse"); // [R07]
endmodule

/* core/sdw_pkg.sv */
// Package for the split-ring descriptor walker: constants, states and carriers.
// Assumes one 100 MHz clock and a memory read port that returns whole 16-byte descriptors.
package sdw_pkg;

    // ------------------------------------------------------------
    // Descriptor layout and queue limits.
    // ------------------------------------------------------------
    localparam int unsigned DESC_BYTES      = 16;           // One descriptor is 16 bytes.
    localparam int unsigned DESC_SHIFT      = 4;            // log2 of descriptor size.
    localparam int unsigned QSIZE_MAX       = 32768;        // Largest legal queue size.
    localparam int unsigned IDX_W           = 16;           // Width of indices and queue size.
    localparam int unsigned CNT_W           = 17;           // Chain counter width.
    localparam int unsigned QALIGN_DEFAULT  = 4096;         // Legacy queue alignment.
    localparam int unsigned DT_ALIGN        = 16;           // Descriptor table alignment.
    localparam int unsigned AV_ALIGN        = 2;            // Available ring alignment.
    localparam int unsigned US_ALIGN        = 4;            // Used ring alignment.
    localparam int unsigned FIFO_DEPTH      = 16;           // Output buffer depth.

    // Flag bits inside the 16-bit flags field.
    localparam logic [15:0] FLAG_CHAIN      = 16'h0001;     // Chain continues at next.
    localparam logic [15:0] FLAG_DEV_WR     = 16'h0002;     // Buffer is device-writable.
    localparam logic [15:0] FLAG_INDIRECT   = 16'h0004;     // Points to an indirect table.

    // Bit positions inside a raw little-endian descriptor.
    localparam int unsigned ADDR_LSB        = 0;
    localparam int unsigned LEN_LSB         = 64;
    localparam int unsigned FLAGS_LSB       = 96;
    localparam int unsigned NEXT_LSB        = 112;

    // Error codes.
    localparam logic [1:0]  ERR_NONE        = 2'h0;
    localparam logic [1:0]  ERR_RANGE       = 2'h1;         // Next index out of range.
    localparam int unsigned ERR_LONG_I      = 2;            // Chain too long.
    localparam logic [1:0]  ERR_LONG        = 2'h2;
    localparam logic [1:0]  ERR_ORDER       = 2'h3;         // Readable after writable.

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    // Walker states, Gray coded along idle, fetch, wait, emit.
    typedef enum logic [2:0] {
        SDW_IDLE  = 3'h0,
        SDW_FETCH = 3'h1,
        SDW_WAIT  = 3'h3,
        SDW_EMIT  = 3'h2,
        SDW_ERR   = 3'h6
    } sdw_state_t;

    // One decoded buffer segment handed to the data engine.
    typedef struct packed {
        logic [63:0] addr;      // Guest-physical buffer address.
        logic [31:0] len;       // Buffer length in bytes.
        logic        dev_wr;    // Device-writable when set.
        logic        last;      // Final segment of the request.
    } sdw_seg_t;

    // Decoded descriptor fields.
    typedef struct packed {
        logic [63:0] addr;
        logic [31:0] len;
        logic [15:0] flags;
        logic [15:0] next;
    } sdw_desc_t;

    // Memory read request.
    typedef struct packed {
        logic [63:0] addr;      // Byte address of a descriptor.
    } sdw_mreq_t;

endpackage

/* core/sdw_fifo.sv */
// Synchronous FIFO that buffers decoded segments toward the data engine.
// Assumes a single clock, a synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module sdw_fifo #(
    parameter int unsigned WIDTH = 98,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // ------------------------------------------------------------
    // Storage and pointers.
    // ------------------------------------------------------------
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];     // Word storage.
    logic [AW-1:0]    wr_q, wr_d;        // Write pointer.
    logic [AW-1:0]    rd_q, rd_d;        // Read pointer.
    logic [AW:0]      cnt_q, cnt_d;      // Fill level.
    logic             push, pop;

    // Full and empty come straight from the fill count.
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // Next pointer values.
    always_comb begin
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready;
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // Registers; storage has no reset because pointers guard it.
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem_q[wr_q] <= in_data;
            end
        end
    end
endmodule

/* core/sdw_decode.sv */
// Byte-order decode of a raw 16-byte descriptor into its fields.
// Assumes the raw word holds memory byte 0 in bits 7:0.
`timescale 1ns/1ps
module sdw_decode (
    input  wire logic [127:0]     raw,
    input  wire logic             native_be,
    output sdw_pkg::sdw_desc_t    desc
);
    // ------------------------------------------------------------
    // Byte swapping helper.
    // ------------------------------------------------------------
    // Reverses bytes of a field when the guest is big-endian in legacy mode.
    function automatic logic [63:0] swap(input logic [63:0] v, input int unsigned nb,
                                         input logic be);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            if (i < nb) begin
                r[i*8 +: 8] = be ? v[(nb-1-i)*8 +: 8] : v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Field extraction.
    always_comb begin
        desc.addr  = swap(raw[sdw_pkg::ADDR_LSB +: 64], 8, native_be);
        desc.len   = 32'(swap({32'h0, raw[sdw_pkg::LEN_LSB +: 32]}, 4, native_be));
        desc.flags = 16'(swap({48'h0, raw[sdw_pkg::FLAGS_LSB +: 16]}, 2, native_be));
        desc.next  = 16'(swap({48'h0, raw[sdw_pkg::NEXT_LSB +: 16]}, 2, native_be));
    end
endmodule

/* testbench/sdw_mem_model.sv */
// Guest memory model that answers descriptor reads for the walker.
// Assumes the bench fills mem by hierarchical access before each walk.
`timescale 1ns/1ps
module sdw_mem_model (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         mem_req_valid,
    output logic              mem_req_ready,
    input  wire logic [63:0]  mem_req_addr,
    output logic              mem_rsp_valid,
    output logic      [127:0] mem_rsp_data
);
    logic [127:0] mem [logic [59:0]];   // Descriptor store keyed by 16-byte slot.
    logic [59:0]  pend_q;               // Slot of the accepted request.
    int           wait_q;               // Cycles left before the answer.
    logic         busy_q;               // One request outstanding.

    initial begin
        mem_req_ready = 1'b0;
        mem_rsp_valid = 1'b0;
        mem_rsp_data  = 128'h0;
        busy_q        = 1'b0;
        wait_q        = 0;
    end

    // Ready and latency vary at random so prompt and slow answers both occur.
    // Outside a reply the data lines toggle, so stale data is never reused.
    always @(posedge clk) begin
        mem_rsp_valid <= 1'b0;
        mem_rsp_data  <= ~mem_rsp_data;
        if (srst) begin
            busy_q        <= 1'b0;
            mem_req_ready <= 1'b0;
        end else if (busy_q) begin
            if (wait_q == 0) begin
                mem_rsp_valid <= 1'b1;   // One answer per request.
                mem_rsp_data  <= mem.exists(pend_q) ? mem[pend_q] : ~mem_rsp_data;
                busy_q        <= 1'b0;
            end else begin
                wait_q <= wait_q - 1;
            end
        end else if (mem_req_valid && mem_req_ready) begin
            pend_q        <= mem_req_addr[63:4];
            wait_q        <= $urandom % 3;
            busy_q        <= 1'b1;
            mem_req_ready <= 1'b0;
        end else begin
            mem_req_ready <= ($urandom % 3) != 0;
        end
    end
endmodule

/* testbench/tb_split_ring_descriptor_walker.sv */
// Self-checking bench for the descriptor walker with a random memory model.
// Assumes the walker top, its package and its fifo are compiled first.
`timescale 1ns/1ps
module tb_split_ring_descriptor_walker;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, start = 1'b0, hold = 1'b0;
    logic legacy_mode = 1'b0, native_be = 1'b0, seg_ready = 1'b0, chk = 1'b1;
    logic [63:0]  base = 64'h1000, a;   // Table base is 16-aligned.
    logic [31:0]  l;
    logic [15:0]  queue_size = 16'h0020, head_idx = 16'h0000;
    logic         busy, done, error, mem_req_valid, mem_req_ready, mem_rsp_valid, seg_valid;
    logic [1:0]   error_code;
    logic [63:0]  mem_req_addr;
    logic [127:0] mem_rsp_data;
    sdw_pkg::sdw_seg_t seg_data;
    sdw_pkg::sdw_seg_t expq [$];        // Segments still due.
    int fails = 0, num_checks = 0, cyc = 0, it, k, n, r, h;

    always #5 clk = ~clk;

    sdw_walker u_sdw_walker (.clk(clk), .srst(srst), .ce(ce), .table_base(base),
        .queue_size(queue_size), .legacy_mode(legacy_mode), .native_be(native_be),
        .start(start), .head_idx(head_idx), .busy(busy), .done(done), .error(error),
        .error_code(error_code), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
        .mem_req_addr(mem_req_addr), .mem_rsp_valid(mem_rsp_valid),
        .mem_rsp_data(mem_rsp_data), .seg_valid(seg_valid), .seg_ready(seg_ready),
        .seg_data(seg_data));
    sdw_mem_model u_mem (.clk(clk), .srst(srst), .mem_req_valid(mem_req_valid),
        .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
        .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

    task automatic check(input logic [127:0] seen, input logic [127:0] want, input string m);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Reverse the byte order of the low nb bytes of a field.
    function automatic logic [63:0] sw(input logic [63:0] v, input int nb);
        logic [63:0] o = 64'h0;
        for (int i = 0; i < nb; i++) o[8*i+:8] = v[8*(nb-1-i)+:8];
        return o;
    endfunction

    // Legacy big-endian guests store fields byte-swapped, else little-endian.
    task automatic put(input logic [63:0] t, input int idx, input logic [63:0] ad,
                       input logic [31:0] ln, input logic [15:0] f, input logic [15:0] nx);
        logic sb = legacy_mode && native_be;
        u_mem.mem[t[63:4] + 60'(idx)] = sb ? {16'(sw(nx, 2)), 16'(sw(f, 2)),
            32'(sw(ln, 4)), sw(ad, 8)} : {nx, f, ln, ad};
    endtask

    task automatic expect_seg(input logic [63:0] ad, input logic [31:0] ln, input logic w,
                              input logic last);
        expq.push_back(sdw_pkg::sdw_seg_t'{ad, ln, w, last});
    endtask

    // Segments taken by the data engine must match in order.
    always @(posedge clk) begin
        if (!srst && seg_valid && seg_ready && chk) begin
            if (expq.size() == 0) check(1, 0, "extra segment");
            else check(seg_data, expq.pop_front(), "segment");
        end
    end

    // The sink stalls at random, or fully while hold is set.
    always @(negedge clk) seg_ready <= hold ? 1'b0 : (($urandom % 4) != 0);

    // A hang ends the run with a counted failure.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            summarize();
        end
    end

    task automatic run(input logic [15:0] hd, input logic [15:0] qs, input logic [1:0] code);
        int w = 0;
        @(negedge clk);
        chk = (code == sdw_pkg::ERR_NONE);
        start = 1'b1;
        head_idx = hd;
        queue_size = qs;
        @(negedge clk);
        start = 1'b0;
        if (hold) begin
            repeat (400) @(negedge clk);
            check(busy, 1, "walk not stalled by full buffer");
            check(seg_valid, 1, "buffer empty while stalled");
            hold = 1'b0;
        end
        while (done !== 1'b1 && w < 3000) begin
            @(negedge clk);
            w++;
        end
        check(done, 1, "no completion");
        check(error_code, code, "error code");
        check(error, code != sdw_pkg::ERR_NONE, "error flag");
        while ((expq.size() != 0 || seg_valid !== 1'b0) && w < 6000) begin
            @(negedge clk);
            w++;
        end
        check(expq.size(), 0, "missing segments");
    endtask

    initial begin
        void'($urandom(15452));
        repeat (4) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        // Random chains, readable before writable, with every byte-order mode.
        for (it = 0; it < 8; it++) begin
            legacy_mode = it[0];
            native_be = it[1];
            n = 1 + $urandom % 6;
            r = $urandom % (n + 1);
            h = $urandom % 32;
            for (k = 0; k < n; k++) begin
                a = {$urandom, $urandom};
                l = $urandom;
                put(base, (h + 7 * k) % 32, a, l, (k < n - 1 ? sdw_pkg::FLAG_CHAIN : 16'h0)
                    | (k >= r ? sdw_pkg::FLAG_DEV_WR : 16'h0), 16'((h + 7 * (k + 1)) % 32));
                expect_seg(a, l, k >= r, k == n - 1);
            end
            run(16'(h), 16'h0020, sdw_pkg::ERR_NONE);
        end
        legacy_mode = 1'b0;
        // Sequential chain longer than the buffer while the sink stalls.
        for (k = 0; k < 20; k++) begin
            put(base, k, 64'(k * 64), 32'h40, k < 19 ? sdw_pkg::FLAG_CHAIN : 16'h0, 16'(k + 1));
            expect_seg(64'(k * 64), 32'h40, 1'b0, k == 19);
        end
        hold = 1'b1;
        run(16'h0000, 16'h0020, sdw_pkg::ERR_NONE);
        // Ordinary head then a writable-flagged indirect tail of three entries.
        put(base, 5, 64'hA000, 32'h10, sdw_pkg::FLAG_CHAIN, 16'h0009);
        put(base, 9, 64'h2000, 32'h30, sdw_pkg::FLAG_INDIRECT | sdw_pkg::FLAG_DEV_WR, 0);
        put(64'h2000, 0, 64'hB000, 32'h11, sdw_pkg::FLAG_CHAIN, 16'h0001);
        put(64'h2000, 1, 64'hC000, 32'h12, sdw_pkg::FLAG_CHAIN | sdw_pkg::FLAG_DEV_WR, 2);
        put(64'h2000, 2, 64'hD000, 32'h13, sdw_pkg::FLAG_DEV_WR, 16'h0000);
        expect_seg(64'hA000, 32'h10, 1'b0, 1'b0);
        expect_seg(64'hB000, 32'h11, 1'b0, 1'b0);
        expect_seg(64'hC000, 32'h12, 1'b1, 1'b0);
        expect_seg(64'hD000, 32'h13, 1'b1, 1'b1);
        run(16'h0005, 16'h0020, sdw_pkg::ERR_NONE);
        // Faulty tables: index out of range, a loop, writable before readable.
        put(base, 3, 64'h0, 32'h4, sdw_pkg::FLAG_CHAIN, 16'h0008);
        run(16'h0003, 16'h0008, sdw_pkg::ERR_RANGE);
        for (k = 0; k < 4; k++) put(base, k, 64'h0, 32'h4, sdw_pkg::FLAG_CHAIN, 16'((k + 1) % 4));
        run(16'h0000, 16'h0004, sdw_pkg::ERR_LONG);
        put(base, 0, 64'h0, 32'h4, sdw_pkg::FLAG_CHAIN | sdw_pkg::FLAG_DEV_WR, 16'h0001);
        put(base, 1, 64'h0, 32'h4, 16'h0000, 16'h0000);
        run(16'h0000, 16'h0008, sdw_pkg::ERR_ORDER);
        // Largest queue, last entry, clears the earlier error.
        put(base, 32767, 64'hE000, 32'h20, 16'h0000, 16'h0000);
        expect_seg(64'hE000, 32'h20, 1'b0, 1'b1);
        run(16'h7FFF, 16'h8000, sdw_pkg::ERR_NONE);
        summarize();
    end
endmodule
